// [logic/imsr_top.sv]
// error flags, command, identification and scratch registers behind spi
`timescale 1ns/10ps
// Functional notes
// - clock error flag in scaled sync mode
// - flash crc test mismatch sets memory flag
// - self test sensor failure sets flag
// - low supply flags, halts; resume after 250ms
// - sclk count not multiple of sixteen flagged
// - failed flash update sets flag
// - overrun flag; reset pin or command recovers
// - reading error flags clears them all
// - flags stay set until read or command reset
// - persisting condition sets flag again
// - rate is 32 bits over two words
// - bias period read-write, default 0x070A
// - three read-write scratch registers
// - flash write count over two words
// - firmware revision and date read-only
module imsr_top #(
    parameter int RECOVER_CYCLES = imsr_pkg::RECOVER_CYC,
    parameter logic [15:0] DEVICE_NUMBER = imsr_pkg::DEV_ID_DEF,
    parameter logic [15:0] SERIAL_NUMBER = imsr_pkg::SERIAL_DEF,
    parameter logic [15:0] FW_REVISION = imsr_pkg::FW_REV_DEF,
    parameter logic [15:0] FW_DAY_MONTH = imsr_pkg::FW_DM_DEF,
    parameter logic [15:0] FW_YEAR = imsr_pkg::FW_Y_DEF
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    input wire logic [2:0] sync_mode_i,
    input wire logic sync_unlocked_i,
    input wire logic supply_low_i,
    input wire logic overrun_i,
    input wire logic flash_test_done_i,
    input wire logic flash_crc_bad_i,
    input wire logic self_test_done_i,
    input wire logic sensor_fail_i,
    input wire logic flash_update_done_i,
    input wire logic flash_update_fail_i,
    input wire logic [31:0] x_rate_i,
    input wire logic [31:0] y_rate_i,
    input wire logic [31:0] z_rate_i,
    input wire logic [31:0] flash_write_count_i,
    output logic [15:0] global_command_o,
    output logic [15:0] bias_estimation_period_o,
    output logic standby_o
);
    import imsr_pkg::*;

    imsr_spi_if spi();

    imsr_spi_phy u_phy (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .spi_sclk_i(spi_sclk_i),
        .spi_cs_n_i(spi_cs_n_i),
        .spi_mosi_i(spi_mosi_i),
        .spi_miso_o(spi_miso_o),
        .spi_miso_oe_o(spi_miso_oe_o),
        .bus(spi.phy)
    );

    logic req_wr, wr_lo, wr_hi, rd_req, rd_clear, soft_rst;
    logic [6:0] req_addr, word_addr;
    logic [7:0] wr_byte;
    logic [7:1] flags;
    logic [7:1] flag_set;
    logic [7:1] live_set;
    logic mem_bad, sens_bad, upd_bad;
    logic sup_m, sup_s;
    logic [CNT_W-1:0] rec_cnt;
    logic [15:0] scr1, scr2, scr3;
    logic [15:0] tx_word;
    logic [15:0] rd_data;

    ////////////////////////////////////////////////////////////
    // request decode: bit 15 write, 14:8 address, 7:0 write byte
    assign req_wr = spi.word[W_BIT];
    assign req_addr = spi.word[14:8];
    assign word_addr = {req_addr[6:1], 1'b0};
    assign wr_byte = spi.word[7:0];
    assign wr_lo = spi.word_valid & req_wr & ~req_addr[0];
    assign wr_hi = spi.word_valid & req_wr & req_addr[0];
    assign rd_req = spi.word_valid & ~req_wr;
    assign rd_clear = rd_req & (word_addr == A_ERR);
    assign soft_rst = global_command_o[C_RESET];
    assign spi.tx_word = tx_word;

    function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi, input logic [7:0] b);
        put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
    endfunction

    ////////////////////////////////////////////////////////////
    // supply monitor is analog, so it is synchronised first
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sup_m <= 1'b0;
            sup_s <= 1'b0;
        end else begin
            sup_m <= supply_low_i;
            sup_s <= sup_m;
        end
    end

    // recovery needs an unbroken stretch of good supply
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            standby_o <= 1'b0;
            rec_cnt <= '0;
        end else if (sup_s) begin
            standby_o <= 1'b1;
            rec_cnt <= '0;
        end else if (standby_o) begin
            if (rec_cnt == CNT_W'(RECOVER_CYCLES - 1)) begin
                standby_o <= 1'b0;
                rec_cnt <= '0;
            end else begin
                rec_cnt <= rec_cnt + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // test results are held so a failure keeps re-raising its flag
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mem_bad <= 1'b0;
            sens_bad <= 1'b0;
            upd_bad <= 1'b0;
        end else if (soft_rst) begin
            mem_bad <= 1'b0;
            sens_bad <= 1'b0;
            upd_bad <= 1'b0;
        end else begin
            if (flash_test_done_i) begin
                mem_bad <= flash_crc_bad_i;
            end
            if (self_test_done_i) begin
                sens_bad <= sensor_fail_i;
            end
            if (flash_update_done_i) begin
                upd_bad <= flash_update_fail_i;
            end
        end
    end

    always_comb begin
        flag_set[F_CLK] = (sync_mode_i == SYNC_SCALED) & sync_unlocked_i;
        flag_set[F_MEM] = mem_bad | (flash_test_done_i & flash_crc_bad_i);
        flag_set[F_SENS] = sens_bad | (self_test_done_i & sensor_fail_i);
        flag_set[F_STBY] = standby_o | sup_s;
        flag_set[F_FRM] = spi.frame_err;
        flag_set[F_UPD] = upd_bad | (flash_update_done_i & flash_update_fail_i);
        flag_set[F_OVR] = overrun_i;
        // a command reset drops held test results, so only live causes reload
        live_set = flag_set;
        live_set[F_MEM] = flash_test_done_i & flash_crc_bad_i;
        live_set[F_SENS] = self_test_done_i & sensor_fail_i;
        live_set[F_UPD] = flash_update_done_i & flash_update_fail_i;
    end

    // set is ored in after the clear, so a same-cycle event survives
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags <= '0;
        end else if (soft_rst) begin
            flags <= live_set;
        end else begin
            flags <= (rd_clear ? 7'h00 : flags) | flag_set;
        end
    end

    ////////////////////////////////////////////////////////////
    // command bits are pulses only; nothing is kept for readback
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            global_command_o <= 16'h0000;
        end else if (word_addr == A_CMD && wr_lo) begin
            global_command_o <= {8'h00, wr_byte};
        end else if (word_addr == A_CMD && wr_hi) begin
            global_command_o <= {wr_byte, 8'h00};
        end else begin
            global_command_o <= 16'h0000;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bias_estimation_period_o <= BIAS_RST;
        end else if (word_addr == A_BIAS && (wr_lo || wr_hi)) begin
            bias_estimation_period_o <= put_byte(bias_estimation_period_o, wr_hi, wr_byte);
        end
    end

    // scratch contents survive the command reset, as flash would
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scr1 <= SCR_RST;
            scr2 <= SCR_RST;
            scr3 <= SCR_RST;
        end else if (wr_lo || wr_hi) begin
            if (word_addr == A_SCR1) begin
                scr1 <= put_byte(scr1, wr_hi, wr_byte);
            end
            if (word_addr == A_SCR2) begin
                scr2 <= put_byte(scr2, wr_hi, wr_byte);
            end
            if (word_addr == A_SCR3) begin
                scr3 <= put_byte(scr3, wr_hi, wr_byte);
            end
        end
    end

    ////////////////////////////////////////////////////////////
    always_comb begin
        case (word_addr)
            A_ERR: rd_data = {8'h00, flags, 1'b0};
            A_XLO: rd_data = x_rate_i[15:0];
            A_XHI: rd_data = x_rate_i[31:16];
            A_YLO: rd_data = y_rate_i[15:0];
            A_YHI: rd_data = y_rate_i[31:16];
            A_ZLO: rd_data = z_rate_i[15:0];
            A_ZHI: rd_data = z_rate_i[31:16];
            A_BIAS: rd_data = bias_estimation_period_o;
            A_FREV: rd_data = FW_REVISION;
            A_FDM: rd_data = FW_DAY_MONTH;
            A_FY: rd_data = FW_YEAR;
            A_DEV: rd_data = DEVICE_NUMBER;
            A_SER: rd_data = SERIAL_NUMBER;
            A_SCR1: rd_data = scr1;
            A_SCR2: rd_data = scr2;
            A_SCR3: rd_data = scr3;
            A_FLO: rd_data = flash_write_count_i[15:0];
            A_FHI: rd_data = flash_write_count_i[31:16];
            default: rd_data = 16'h0000;
        endcase
    end

    // answer goes out in the following word; writes answer zero
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_word <= 16'h0000;
        end else if (rd_req) begin
            tx_word <= rd_data;
        end else if (spi.word_valid) begin
            tx_word <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_clk_err;
        (sync_mode_i == SYNC_SCALED) && sync_unlocked_i |=> flags[F_CLK];
    endproperty
    a_clk_err: assert property (p_clk_err) else $error("clock error flag not set");

    property p_mem_err;
        flash_test_done_i && flash_crc_bad_i && !soft_rst |=> flags[F_MEM] ##1 (flags[F_MEM] || $past(soft_rst));
    endproperty
    a_mem_err: assert property (p_mem_err) else $error("memory flag not set or not held");

    property p_sens_err;
        self_test_done_i && sensor_fail_i |=> flags[F_SENS];
    endproperty
    a_sens_err: assert property (p_sens_err) else $error("sensor flag not set");

    property p_stby;
        sup_s |=> standby_o && flags[F_STBY];
    endproperty
    a_stby: assert property (p_stby) else $error("standby not entered");

    property p_resume;
        $fell(standby_o) |-> $past(rec_cnt) == CNT_W'(RECOVER_CYCLES - 1);
    endproperty
    a_resume: assert property (p_resume) else $error("standby left early");

    property p_frame;
        spi.frame_err |=> flags[F_FRM];
    endproperty
    a_frame: assert property (p_frame) else $error("framing flag not set");

    property p_upd_err;
        flash_update_done_i && flash_update_fail_i |=> flags[F_UPD];
    endproperty
    a_upd_err: assert property (p_upd_err) else $error("update flag not set");

    property p_ovr;
        overrun_i |=> flags[F_OVR];
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun flag not set");

    property p_clear;
        rd_clear && !soft_rst && (flag_set == 7'h00) |=> flags == 7'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("read did not clear flags");

    property p_sticky;
        !rd_clear && !soft_rst |=> (flags & $past(flags)) == $past(flags);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without read");

    property p_set_wins;
        rd_clear && overrun_i |=> flags[F_OVR];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a set");

    property p_rsv;
        rd_clear |=> tx_word[15:8] == 8'h00 && tx_word[0] == 1'b0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved flag bits not zero");

    property p_rate;
        rd_req && (word_addr == A_XHI) |=> tx_word == $past(x_rate_i[31:16]);
    endproperty
    a_rate: assert property (p_rate) else $error("rate high word wrong");

    property p_cmd;
        wr_lo && (word_addr == A_CMD) |=> global_command_o == {8'h00, $past(wr_byte)} ##1 global_command_o == 16'h0000;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command pulse wrong");

    property p_bias;
        wr_lo && (word_addr == A_BIAS) |=> bias_estimation_period_o[7:0] == $past(wr_byte);
    endproperty
    a_bias: assert property (p_bias) else $error("bias low byte not written");

    property p_soft;
        soft_rst |=> !mem_bad && !sens_bad && !upd_bad && (flags == $past(live_set));
    endproperty
    a_soft: assert property (p_soft) else $error("command reset left stale state");

    c_set_wins: cover property (rd_clear && overrun_i);
    c_read_clear: cover property (rd_clear && flags != 7'h00);
    c_resume: cover property ($fell(standby_o));
    c_reset_cmd: cover property (soft_rst);
endmodule

// [logic/imsr_pkg.sv]
// constants for the status and identification register block
package imsr_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int RECOVER_MS = 250;
    localparam int RECOVER_CYC = RECOVER_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 25;
    localparam int WORD_BITS = 16;
    localparam int W_BIT = 15;
    localparam logic [3:0] LAST_BIT = 4'hF;
    // byte addresses; a word sits at an even address
    localparam logic [6:0] A_ERR = 7'h02;
    localparam logic [6:0] A_XLO = 7'h04;
    localparam logic [6:0] A_XHI = 7'h06;
    localparam logic [6:0] A_YLO = 7'h08;
    localparam logic [6:0] A_YHI = 7'h0A;
    localparam logic [6:0] A_ZLO = 7'h0C;
    localparam logic [6:0] A_ZHI = 7'h0E;
    localparam logic [6:0] A_BIAS = 7'h66;
    localparam logic [6:0] A_CMD = 7'h68;
    localparam logic [6:0] A_FREV = 7'h6C;
    localparam logic [6:0] A_FDM = 7'h6E;
    localparam logic [6:0] A_FY = 7'h70;
    localparam logic [6:0] A_DEV = 7'h72;
    localparam logic [6:0] A_SER = 7'h74;
    localparam logic [6:0] A_SCR1 = 7'h76;
    localparam logic [6:0] A_SCR2 = 7'h78;
    localparam logic [6:0] A_SCR3 = 7'h7A;
    localparam logic [6:0] A_FLO = 7'h7C;
    localparam logic [6:0] A_FHI = 7'h7E;
    // error flag positions
    localparam int F_OVR = 1;
    localparam int F_UPD = 2;
    localparam int F_FRM = 3;
    localparam int F_STBY = 4;
    localparam int F_SENS = 5;
    localparam int F_MEM = 6;
    localparam int F_CLK = 7;
    // command bit positions
    localparam int C_SELFTEST = 2;
    localparam int C_FUPD = 3;
    localparam int C_FTEST = 4;
    localparam int C_RESET = 7;
    localparam logic [2:0] SYNC_SCALED = 3'h2;
    localparam logic [15:0] BIAS_RST = 16'h070A;
    localparam logic [15:0] SCR_RST = 16'h0000;
    // identity defaults, values arbitrary
    localparam logic [15:0] DEV_ID_DEF = 16'h1234;
    localparam logic [15:0] SERIAL_DEF = 16'h0001;
    localparam logic [15:0] FW_REV_DEF = 16'h0100;
    localparam logic [15:0] FW_DM_DEF = 16'h0101;
    localparam logic [15:0] FW_Y_DEF = 16'h2000;
endpackage

// [logic/imsr_spi_if.sv]
// word carrier between the serial front end and the register core
`timescale 1ns/10ps
interface imsr_spi_if;
    logic word_valid;
    logic [15:0] word;
    logic frame_err;
    logic [15:0] tx_word;
    modport phy (output word_valid, output word, output frame_err, input tx_word);
    modport core (input word_valid, input word, input frame_err, output tx_word);
endinterface

// [logic/imsr_spi_phy.sv]
// serial front end: sclk idle high, shift out on fall, sample on rise
`timescale 1ns/10ps
module imsr_spi_phy (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    imsr_spi_if.phy bus
);
    import imsr_pkg::*;

    logic sck_m, sck_s, sck_d, cs_m, cs_s, cs_d, mosi_m, mosi_s;
    logic [3:0] bit_cnt;
    logic [15:0] rx_sh;
    logic [15:0] tx_sh;
    logic rise, fall, cs_act, cs_end;

    ////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sck_m <= 1'b1;
            sck_s <= 1'b1;
            sck_d <= 1'b1;
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            cs_d <= 1'b1;
            mosi_m <= 1'b0;
            mosi_s <= 1'b0;
        end else begin
            sck_m <= spi_sclk_i;
            sck_s <= sck_m;
            sck_d <= sck_s;
            cs_m <= spi_cs_n_i;
            cs_s <= cs_m;
            cs_d <= cs_s;
            mosi_m <= spi_mosi_i;
            mosi_s <= mosi_m;
        end
    end

    assign rise = sck_s & ~sck_d;
    assign fall = ~sck_s & sck_d;
    assign cs_act = ~cs_s;
    assign cs_end = cs_s & ~cs_d;

    ////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bit_cnt <= 4'h0;
            rx_sh <= 16'h0000;
            bus.word <= 16'h0000;
            bus.word_valid <= 1'b0;
            bus.frame_err <= 1'b0;
        end else begin
            bus.word_valid <= 1'b0;
            bus.frame_err <= 1'b0;
            if (cs_end) begin
                // leftover clocks mean the frame was not whole words
                bus.frame_err <= (bit_cnt != 4'h0);
                bit_cnt <= 4'h0;
            end else if (cs_act && rise) begin
                rx_sh <= {rx_sh[14:0], mosi_s};
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == LAST_BIT) begin
                    bus.word <= {rx_sh[14:0], mosi_s};
                    bus.word_valid <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            spi_miso_o <= 1'b0;
            spi_miso_oe_o <= 1'b0;
            tx_sh <= 16'h0000;
        end else begin
            spi_miso_oe_o <= cs_act;
            if (cs_act && fall) begin
                if (bit_cnt == 4'h0) begin
                    spi_miso_o <= bus.tx_word[W_BIT];
                    tx_sh <= {bus.tx_word[14:0], 1'b0};
                end else begin
                    spi_miso_o <= tx_sh[W_BIT];
                    tx_sh <= {tx_sh[14:0], 1'b0};
                end
            end
        end
    end
endmodule

// [test/imsr_spi_host.sv]
// spi host model: mode 3 master, one word per chip-select frame
`timescale 1ns/10ps
module imsr_spi_host #(
    parameter int HALF = 8
) (
    input wire logic ref_clk_i,
    input wire logic spi_miso_i,
    output logic spi_sclk_o,
    output logic spi_cs_n_o,
    output logic spi_mosi_o
);
    initial begin
        spi_sclk_o = 1'b1;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // half period kept well above the three clocks the synchroniser needs
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        spi_cs_n_o <= 1'b0;
        wait_clk(HALF);
        for (int i = 0; i < nbits; i++) begin
            spi_sclk_o <= 1'b0;
            spi_mosi_o <= tx[15 - i];
            wait_clk(HALF);
            spi_sclk_o <= 1'b1;
            rx = {rx[14:0], spi_miso_i};
            wait_clk(HALF);
        end
        spi_cs_n_o <= 1'b1;
        // idle line shows the inverse so stale data cannot pass
        spi_mosi_o <= ~spi_mosi_o;
        wait_clk(HALF);
    endtask
endmodule

// [test/imsr_status_and_id_registers_tb.sv]
// self-checking bench for the status, identification and scratch registers
`timescale 1ns/10ps
module imu_status_and_id_registers_tb;
    import imsr_pkg::*;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, standby;
    logic [2:0] sync_mode = 3'h0;
    logic unlocked = 1'b0;
    logic supply_low = 1'b0;
    logic overrun = 1'b0;
    logic [2:0] done = 3'h0;
    logic [2:0] fail = 3'h0;
    logic [31:0] rate [3];
    logic [31:0] fcount = 32'h0;
    logic [15:0] cmd_o, bias_o;
    logic miso_oe;
    logic [3:0] cs_hist = 4'h0;
    logic [15:0] cmd_or = 16'h0000;
    int cmd_pulses = 0;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 49982;

    imsr_spi_host host (.ref_clk_i(ref_clk_i), .spi_miso_i(spi_miso), .spi_sclk_o(spi_sclk),
        .spi_cs_n_o(spi_cs_n), .spi_mosi_o(spi_mosi));

    // short recovery so the standby exit fits the run
    imsr_top #(.RECOVER_CYCLES(20)) dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .spi_sclk_i(spi_sclk), .spi_cs_n_i(spi_cs_n), .spi_mosi_i(spi_mosi), .spi_miso_o(spi_miso),
        .spi_miso_oe_o(miso_oe), .sync_mode_i(sync_mode), .sync_unlocked_i(unlocked),
        .supply_low_i(supply_low), .overrun_i(overrun), .flash_test_done_i(done[0]),
        .flash_crc_bad_i(fail[0]), .self_test_done_i(done[1]), .sensor_fail_i(fail[1]),
        .flash_update_done_i(done[2]), .flash_update_fail_i(fail[2]), .x_rate_i(rate[0]),
        .y_rate_i(rate[1]), .z_rate_i(rate[2]), .flash_write_count_i(fcount),
        .global_command_o(cmd_o), .bias_estimation_period_o(bias_o), .standby_o(standby));

    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        cs_hist <= {cs_hist[2:0], ~spi_cs_n};
        if (cmd_o !== 16'h0000) begin
            cmd_pulses <= cmd_pulses + 1;
            cmd_or <= cmd_or | cmd_o;
        end
        // only judged once chip select has been steady past the synchroniser
        if (!sys_rst_i && (cs_hist == 4'hF || cs_hist == 4'h0)) check(32'(miso_oe), 32'(cs_hist[0]));
        if (cycles == 90000) begin
            miscompares = miscompares + 1;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checked %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] flag(input int pos);
        return 16'h0001 << pos;
    endfunction

    function automatic int rbit(input int k);
        return k == 0 ? F_MEM : (k == 1 ? F_SENS : F_UPD);
    endfunction

    // high byte at the odd address, low byte at the even one
    task automatic wr(input logic [6:0] a, input logic [15:0] v);
        logic [15:0] r;
        host.xfer({1'b1, a | 7'h01, v[15:8]}, 16, r);
        host.xfer({1'b1, a & 7'h7E, v[7:0]}, 16, r);
    endtask

    // answer arrives during the following word
    task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] r;
        host.xfer({1'b0, a, 8'h00}, 16, r);
        host.xfer(16'h0000, 16, r);
        check(32'(r), 32'(exp));
    endtask

    task automatic result(input int k, input logic bad);
        @(posedge ref_clk_i);
        done[k] <= 1'b1;
        fail[k] <= bad;
        @(posedge ref_clk_i);
        done[k] <= 1'b0;
        fail[k] <= 1'($random(seed));
        repeat (3) @(posedge ref_clk_i);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] v;
        automatic logic [6:0] ro [5] = '{A_FREV, A_FDM, A_FY, A_DEV, A_SER};
        automatic logic [15:0] id [5] = '{FW_REV_DEF, FW_DM_DEF, FW_Y_DEF, DEV_ID_DEF, SERIAL_DEF};
        automatic logic [6:0] rw [4] = '{A_BIAS, A_SCR1, A_SCR2, A_SCR3};
        logic [15:0] w [4];
        for (int i = 0; i < 3; i++) rate[i] = 32'h0;
        tick(6);
        sys_rst_i <= 1'b0;
        tick(4);
        for (int i = 0; i < 4; i++) rd_chk(rw[i], i == 0 ? BIAS_RST : SCR_RST);
        rd_chk(A_ERR, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            wr(ro[i], ~id[i]);
            rd_chk(ro[i], id[i]);
        end
        wr(A_CMD, 16'h0000);
        rd_chk(A_CMD, 16'h0000);
        rd_chk(7'h6A, 16'h0000);
        $display("test reset_and_identity done");

        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 4; i++) begin
                w[i] = (r == 0) ? 16'hFFFF : 16'($random(seed));
                wr(rw[i], w[i]);
            end
            for (int i = 0; i < 4; i++) rd_chk(rw[i], w[i]);
            check(32'(bias_o), 32'(w[0]));
        end
        $display("test read_write done");

        for (int r = 0; r < 3; r++) begin
            @(posedge ref_clk_i);
            for (int i = 0; i < 3; i++) rate[i] <= (r == 0) ? 32'hFFFF_FFFE : 32'($random(seed));
            fcount <= 32'($random(seed));
            tick(2);
            wr(A_FLO, ~fcount[15:0]);
            for (int i = 0; i < 3; i++) begin
                rd_chk(A_XLO + 7'(4 * i), rate[i][15:0]);
                rd_chk(A_XHI + 7'(4 * i), rate[i][31:16]);
            end
            rd_chk(A_FLO, fcount[15:0]);
            rd_chk(A_FHI, fcount[31:16]);
        end
        $display("test wide_values done");

        for (int k = 0; k < 3; k++) begin
            result(k, 1'b1);
            rd_chk(A_ERR, flag(rbit(k)));
            rd_chk(A_ERR, flag(rbit(k)));
            result(k, 1'b0);
            rd_chk(A_ERR, flag(rbit(k)));
            rd_chk(A_ERR, 16'h0000);
        end
        overrun <= 1'b1;
        tick(1);
        overrun <= 1'b0;
        tick(50);
        rd_chk(A_ERR, flag(F_OVR));
        rd_chk(A_ERR, 16'h0000);
        // overrun held across the clearing read: the set must survive it
        overrun <= 1'b1;
        rd_chk(A_ERR, flag(F_OVR));
        overrun <= 1'b0;
        rd_chk(A_ERR, flag(F_OVR));
        rd_chk(A_ERR, 16'h0000);
        $display("test result_flags done");

        unlocked <= 1'b1;
        for (int m = 0; m < 8; m++) begin
            if (m != 2) begin
                sync_mode <= 3'(m);
                tick(4);
                rd_chk(A_ERR, 16'h0000);
            end
        end
        sync_mode <= SYNC_SCALED;
        tick(4);
        rd_chk(A_ERR, flag(F_CLK));
        rd_chk(A_ERR, flag(F_CLK));
        unlocked <= 1'b0;
        tick(4);
        rd_chk(A_ERR, flag(F_CLK));
        rd_chk(A_ERR, 16'h0000);
        $display("test clock_flag done");

        supply_low <= 1'b1;
        tick(10);
        check(32'(standby), 32'h1);
        supply_low <= 1'b0;
        tick(12);
        check(32'(standby), 32'h1);
        tick(20);
        check(32'(standby), 32'h0);
        rd_chk(A_ERR, flag(F_STBY));
        $display("test standby done");

        host.xfer({1'b1, A_SCR1, 8'h5A}, 8, v);
        rd_chk(A_ERR, flag(F_FRM));
        wr(A_SCR1, 16'hA55A);
        rd_chk(A_SCR1, 16'hA55A);
        rd_chk(A_ERR, 16'h0000);
        $display("test framing done");

        for (int b = 2; b < 5; b++) begin
            cmd_pulses = 0;
            cmd_or = 16'h0000;
            host.xfer({1'b1, A_CMD, 8'(1 << b)}, 16, v);
            tick(10);
            check(32'(cmd_pulses), 32'h1);
            check(32'(cmd_or), 32'(flag(b)));
        end
        result(2, 1'b1);
        host.xfer({1'b1, A_CMD, 8'h80}, 16, v);
        tick(10);
        rd_chk(A_ERR, 16'h0000);
        rd_chk(A_BIAS, w[0]);
        sys_rst_i <= 1'b1;
        tick(3);
        sys_rst_i <= 1'b0;
        tick(4);
        rd_chk(A_BIAS, BIAS_RST);
        $display("test commands_and_reset done");
        report_and_stop();
    end
endmodule
